// File: pkg/wim_defs.vh
// Constants, register map and field layout of the wake input monitor.
// Contract
// - Each wake pin reports an event on a rising and on a falling transition alike.
// - In normal and stop mode an accepted wake pin event raises the interrupt, not a wake-up.
// - In sleep and fail-safe mode an accepted wake pin event wakes the device up.
// - Each wake pin is sensed either statically all the time or cyclically in a timer window.
// - A crossing starts the filter interval and the event counts only if no re-crossing occurs.
// - Filter field 00 static 16 us, 01 static 64 us, 10 cyclic timer one 16 us, 11 timer two.
// - In cyclic mode the period and on-time come from the timer that the filter field selects.
// - Wake capability is enabled per wake pin by a software-written control register.
// - The pin that caused a wake is recorded in a per-pin wake source status bit.
// - The level of every wake pin is readable in a level status register, enabled or not.
// - During cyclic sensing the level status shows the last sampled level of each pin.
// - Alternate-function pins used as wake inputs use a fixed 16 us static filter and own status.
// - Pull field 00 selects no source, 01 pull-down, 10 pull-up.
// - Pull field 11 switches automatically, pull-up on a high level and pull-down on a low one.
// - Measurement enable gates wake pins one and two, drops their pulls and freezes their status.
`ifndef WIM_DEFS_VH
`define WIM_DEFS_VH

`define WIM_CLK_MHZ        125
`define WIM_FLT_SHORT_US   16
`define WIM_FLT_LONG_US    64
`define WIM_CNT_W          14

// Register byte offsets.
`define WIM_OFS_CTRL       8'h00
`define WIM_OFS_WAKE_EN    8'h04
`define WIM_OFS_PULL       8'h08
`define WIM_OFS_FILT       8'h0C
`define WIM_OFS_TMR1       8'h10
`define WIM_OFS_TMR2       8'h14
`define WIM_OFS_WSRC       8'h18
`define WIM_OFS_ALT_WSRC   8'h1C
`define WIM_OFS_LEVEL      8'h20
`define WIM_OFS_IRQ_STAT   8'h24
`define WIM_OFS_IRQ_MASK   8'h28

// Control register fields.
`define WIM_CTRL_MODE      1:0
`define WIM_CTRL_MEAS      2
`define WIM_CTRL_ALT       4:3
`define WIM_MODE_NORMAL    2'h0
`define WIM_MODE_STOP      2'h1
`define WIM_MODE_SLEEP     2'h2
`define WIM_MODE_FAILSAFE  2'h3

// Field codes of the pull and filter selects.
`define WIM_PULL_DOWN      2'h1
`define WIM_PULL_UP        2'h2
`define WIM_PULL_AUTO      2'h3
`define WIM_FLT_STATIC16   2'h0
`define WIM_FLT_STATIC64   2'h1
`define WIM_FLT_CYC_T1     2'h2
`define WIM_FLT_CYC_T2     2'h3

// Timer control fields, counted in microseconds.
`define WIM_TMR_PERIOD     15:0
`define WIM_TMR_ON         31:16

`define WIM_RESP_OKAY      2'h0
`define WIM_RESP_SLVERR    2'h2

`endif

// File: verification/wake_input_monitor_bench.sv
// Self-checking bench of the wake input monitor.
`default_nettype none
`include "wim_defs.vh"
module wake_input_monitor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FS = 20;
   localparam int FL = 40;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [2:0]  drive_en = 3'h7;
   logic [2:0]  drive_level = 3'h0;
   logic [1:0]  alt_in = 2'h0;
   wire logic   awready, wready, bvalid, arready, rvalid, wake_request, irq;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0]  pu, pd, pins;
   int          num_errors = 0;
   int          checks_done = 0;
   int          n;
   wim_top #(.FLT_SHORT_CYC(FS), .FLT_LONG_CYC(FL), .US_TICK_CYC(4)) wim_top_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wake_pin_one(pins[0]), .wake_pin_two(pins[1]), .wake_pin_three(pins[2]),
      .alt_function_outputs(alt_in), .pull_up_en(pu), .pull_down_en(pd),
      .wake_request(wake_request), .irq(irq));
   wim_switches wim_switches_inst (.aclk(aclk), .drive_en(drive_en),
      .drive_level(drive_level), .pull_up_en(pu), .pull_down_en(pd), .pin(pins));
   always #4 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int k;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         k++;
      end while (bvalid !== 1'b1 && k < 200);
      // Ready stays up between calls, so a second call never lowers and raises it in one step.
      chk(bresp, er, "bresp");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what,
                     input logic [1:0] er = 2'h0);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         k++;
      end while (rvalid !== 1'b1 && k < 200);
      chk(rdata, exp, what);
      chk(rresp, er, "rresp");
   endtask
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk(irq, 1'b1, "irq raised");
   endtask
   task automatic clear_all();
      wr(`WIM_OFS_IRQ_STAT, 32'h1F);
      wr(`WIM_OFS_WSRC, 32'h7);
      wr(`WIM_OFS_ALT_WSRC, 32'h3);
      chk(irq, 1'b0, "irq cleared");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(`WIM_OFS_WAKE_EN, 32'h0, "enable reset");
      wr(`WIM_OFS_WAKE_EN, 32'h7);
      rd(`WIM_OFS_WAKE_EN, 32'h7, "enable written");
      rd(`WIM_OFS_LEVEL, 32'h0, "level reset");
      rd(8'h40, 32'h0, "unmapped read", `WIM_RESP_SLVERR);
      wr(8'h40, 32'h1, `WIM_RESP_SLVERR);
   endtask
   task automatic t_edges();
      wr(`WIM_OFS_WAKE_EN, 32'h1);
      wr(`WIM_OFS_IRQ_MASK, 32'h1F);
      drive_level[0] <= 1'b1;
      wait_irq();
      chk(n >= FS && n < FL, 1'b1, "short filter span");
      rd(`WIM_OFS_WSRC, 32'h1, "source after rise");
      rd(`WIM_OFS_IRQ_STAT, 32'h1, "irq status rise");
      clear_all();
      drive_level[0] <= 1'b0;
      wait_irq();
      clear_all();
      drive_level[0] <= 1'b1;
      cyc(FS - 8);
      drive_level[0] <= 1'b0;
      drive_level[2] <= 1'b1;
      cyc(60);
      chk(irq, 1'b0, "glitch rejected");
      rd(`WIM_OFS_LEVEL, 32'h4, "level of disabled pin");
      wr(`WIM_OFS_IRQ_MASK, 32'h0);
      drive_level[0] <= 1'b1;
      cyc(60);
      chk(irq, 1'b0, "masked irq");
      wr(`WIM_OFS_IRQ_MASK, 32'h1F);
      chk(irq, 1'b1, "unmasked irq");
      clear_all();
   endtask
   task automatic t_long();
      wr(`WIM_OFS_FILT, 32'h1);
      drive_level[0] <= 1'b0;
      cyc(FS + 10);
      drive_level[0] <= 1'b1;
      cyc(80);
      chk(irq, 1'b0, "long filter rejects");
      drive_level[0] <= 1'b0;
      wait_irq();
      chk(n >= FL && n < FL + 10, 1'b1, "long filter span");
      clear_all();
      wr(`WIM_OFS_TMR1, 32'h00000010);
      wr(`WIM_OFS_FILT, 32'h2);
      drive_level[0] <= 1'b1;
      cyc(80);
      chk(irq, 1'b0, "cyclic window shut");
      wr(`WIM_OFS_TMR1, 32'h00100010);
      wait_irq();
      drive_level[0] <= 1'b0;
      wait_irq();
      clear_all();
   endtask
   task automatic t_sleep();
      wr(`WIM_OFS_WAKE_EN, 32'h2);
      for (int m = `WIM_MODE_SLEEP; m <= `WIM_MODE_FAILSAFE; m++) begin
         wr(`WIM_OFS_CTRL, m);
         drive_level[1] <= ~drive_level[1];
         n = 0;
         while (wake_request !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
         end
         chk(wake_request, 1'b1, "wake request");
         cyc(2);
         chk(irq, 1'b0, "no irq in sleep");
      end
      wr(`WIM_OFS_CTRL, {30'h0, `WIM_MODE_STOP});
      drive_level[1] <= 1'b1;
      wait_irq();
      wr(`WIM_OFS_CTRL, {30'h0, `WIM_MODE_NORMAL});
      rd(`WIM_OFS_WSRC, 32'h2, "source in sleep");
      clear_all();
   endtask
   task automatic t_pull();
      logic [3:0] up_exp = 4'b1100;
      logic [3:0] dn_exp = 4'b0010;
      drive_en[2] <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(`WIM_OFS_PULL, c << 4);
         cyc(40);
         chk(pu[2], up_exp[c], "pull-up");
         chk(pd[2], dn_exp[c], "pull-down");
      end
      drive_en[2] <= 1'b1;
      drive_level[2] <= 1'b0;
      cyc(40);
      chk({pu[2], pd[2]}, 2'b01, "auto low");
   endtask
   task automatic t_meas_alt();
      wr(`WIM_OFS_PULL, 32'h0A);
      wr(`WIM_OFS_WAKE_EN, 32'h3);
      wr(`WIM_OFS_CTRL, 32'h4);
      cyc(3);
      chk({pu[1:0], pd[1:0]}, 4'h0, "gated pulls");
      drive_level[0] <= 1'b1;
      cyc(60);
      chk(irq, 1'b0, "gated pin quiet");
      rd(`WIM_OFS_LEVEL, 32'h2, "gated level");
      drive_level[0] <= 1'b0;
      cyc(60);
      wr(`WIM_OFS_CTRL, 32'h08);
      alt_in[0] <= 1'b1;
      wait_irq();
      chk(n >= FS && n < FL, 1'b1, "alt filter span");
      rd(`WIM_OFS_ALT_WSRC, 32'h1, "alt source");
      rd(`WIM_OFS_IRQ_STAT, 32'h08, "alt irq status");
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge aclk);
      num_errors++;
      complete_run();
   end
   initial begin
      cyc(4);
      aresetn <= 1'b1;
      cyc(1);
      t_regs();
      t_edges();
      t_long();
      t_sleep();
      t_pull();
      t_meas_alt();
      complete_run();
   end
endmodule // wake_input_monitor_bench
`default_nettype wire

// File: verification/wim_monitor.sv
// Checker of the register bus handshake and the wake outputs of the monitor.
`default_nettype none
module wim_monitor (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic [2:0] pull_up_en,
   input wire logic [2:0] pull_down_en,
   input wire logic       wake_request,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_read_refuse: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not retired");
   a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
      else $error("bad write response code");
   a_wake_pulse: assert property (wake_request |=> !wake_request)
      else $error("wake request longer than one cycle");
   a_pull_exclusive: assert property ((pull_up_en & pull_down_en) == 3'h0)
      else $error("pull-up and pull-down on together");
   a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid &&
      !wake_request && !irq) else $error("output active after reset");
endmodule // wim_monitor
bind wim_top wim_monitor wim_monitor_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pull_up_en, .pull_down_en, .wake_request,
   .irq);
`default_nettype wire

// File: verification/wim_switches.sv
// Model of the external switches that drive the three wake pins.
`default_nettype none
module wim_switches (
   input  wire logic       aclk,
   input  wire logic [2:0] drive_en,
   input  wire logic [2:0] drive_level,
   input  wire logic [2:0] pull_up_en,
   input  wire logic [2:0] pull_down_en,
   output logic      [2:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wander = 3'h0;
   // An open pin without a current source wanders every cycle, so no filter accepts it.
   always @(posedge aclk) begin
      wander <= ~wander;
   end
   assign pin = (drive_en & drive_level) | (~drive_en & pull_up_en) |
                (~drive_en & ~pull_up_en & ~pull_down_en & wander);
endmodule // wim_switches
`default_nettype wire

// File: verilog/wim_top.v
// Wake input monitor: filters, cyclic sense timers, pulls, status and AXI4-Lite registers.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`default_nettype none
`include "wim_defs.vh"

module wim_top #(
   parameter FLT_SHORT_CYC = `WIM_FLT_SHORT_US * `WIM_CLK_MHZ,
   parameter FLT_LONG_CYC  = `WIM_FLT_LONG_US * `WIM_CLK_MHZ,
   parameter US_TICK_CYC   = `WIM_CLK_MHZ
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        wake_pin_one,
   input  wire        wake_pin_two,
   input  wire        wake_pin_three,
   input  wire [1:0]  alt_function_outputs,
   output reg  [2:0]  pull_up_en,
   output reg  [2:0]  pull_down_en,
   output reg         wake_request,
   output wire        irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   reg  [4:0]  ctrl;
   reg  [2:0]  wake_enable_control;
   reg  [5:0]  pull_source_control;
   reg  [5:0]  filter_mode_control;
   reg  [31:0] cyclic_timer_one_control;
   reg  [31:0] cyclic_timer_two_control;
   reg  [2:0]  wake_source_status;
   reg  [1:0]  alt_wake_source_status;
   reg  [2:0]  pin_level_status;
   reg  [4:0]  irq_status;
   reg  [4:0]  irq_mask;

   wire [1:0] mode = ctrl[`WIM_CTRL_MODE];
   wire       measurement_enable = ctrl[`WIM_CTRL_MEAS];
   wire [1:0] alt_wake_cfg = ctrl[`WIM_CTRL_ALT];
   wire       active_mode = (mode == `WIM_MODE_NORMAL) || (mode == `WIM_MODE_STOP);

   ////////////////////////////////////////////////////////////////////////////////
   // Microsecond tick and the two cyclic sense timers.

   reg  [7:0]  us_cnt;
   wire        us_tick = (us_cnt == US_TICK_CYC[7:0] - 8'h01);
   reg  [15:0] tmr_cnt [0:1];
   wire [1:0]  tmr_window;

   always @(posedge aclk) begin
      if (!aresetn) begin
         us_cnt <= 8'h00;
      end else if (us_tick) begin
         us_cnt <= 8'h00;
      end else begin
         us_cnt <= us_cnt + 8'h01;
      end
   end

   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1) begin : g_tmr
         wire [31:0] tcfg = (t == 0) ? cyclic_timer_one_control : cyclic_timer_two_control;
         // The window opens at the start of each period and lasts the on-time.
         assign tmr_window[t] = (tmr_cnt[t] < tcfg[`WIM_TMR_ON]);
         always @(posedge aclk) begin
            if (!aresetn) begin
               tmr_cnt[t] <= 16'h0000;
            end else if (us_tick) begin
               if (tmr_cnt[t] + 16'h0001 >= tcfg[`WIM_TMR_PERIOD]) begin
                  tmr_cnt[t] <= 16'h0000;
               end else begin
                  tmr_cnt[t] <= tmr_cnt[t] + 16'h0001;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Input channels: three wake pins, then the two alternate-function pins.

   wire [4:0] pin_in = {alt_function_outputs, wake_pin_three, wake_pin_two, wake_pin_one};
   wire [4:0] chan_lvl;
   wire [4:0] chan_evt;
   wire [4:0] chan_gated;
   wire [4:0] chan_cyclic;

   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_chan
         reg  [2:0]             sync;
         reg                    lvl;
         reg                    evt;
         reg  [`WIM_CNT_W-1:0]  cnt;
         wire [1:0]             fsel;
         wire [`WIM_CNT_W-1:0]  limit;
         wire                   active;
         if (i < 3) begin : g_wk
            assign fsel = filter_mode_control[2*i+1:2*i];
            assign limit = (fsel == `WIM_FLT_STATIC64) ? FLT_LONG_CYC[`WIM_CNT_W-1:0] :
                           FLT_SHORT_CYC[`WIM_CNT_W-1:0];
            assign active = (fsel == `WIM_FLT_CYC_T1) ? tmr_window[0] :
                            (fsel == `WIM_FLT_CYC_T2) ? tmr_window[1] : 1'b1;
            assign chan_gated[i] = (i < 2) && measurement_enable;
         end else begin : g_alt
            assign fsel = `WIM_FLT_STATIC16;
            assign limit = FLT_SHORT_CYC[`WIM_CNT_W-1:0];
            assign active = 1'b1;
            assign chan_gated[i] = !alt_wake_cfg[i-3];
         end
         assign chan_cyclic[i] = fsel[1];
         assign chan_lvl[i] = lvl;
         assign chan_evt[i] = evt;

         always @(posedge aclk) begin
            if (!aresetn) begin
               sync <= 3'h0;
               lvl  <= 1'b0;
               evt  <= 1'b0;
               cnt  <= {`WIM_CNT_W{1'b0}};
            end else begin
               sync <= {sync[1:0], pin_in[i]};
               evt  <= 1'b0;
               // A bounce back, a gated input or a closed window restarts the interval.
               if (chan_gated[i] || !active || (sync[1] != sync[2]) || (sync[2] == lvl)) begin
                  cnt <= {`WIM_CNT_W{1'b0}};
               end else if (cnt >= limit - {{(`WIM_CNT_W-1){1'b0}}, 1'b1}) begin
                  lvl <= sync[2];
                  evt <= 1'b1;
                  cnt <= {`WIM_CNT_W{1'b0}};
               end else begin
                  cnt <= cnt + {{(`WIM_CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   endgenerate

   wire [2:0] wk_evt  = chan_evt[2:0] & wake_enable_control & ~chan_gated[2:0];
   wire [1:0] alt_evt = chan_evt[4:3] & ~chan_gated[4:3];

   ////////////////////////////////////////////////////////////////////////////////
   // Pull current sources.

   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_pull
         wire [1:0] psel = pull_source_control[2*p+1:2*p];
         always @(posedge aclk) begin
            if (!aresetn) begin
               pull_up_en[p]   <= 1'b0;
               pull_down_en[p] <= 1'b0;
            end else if (chan_gated[p]) begin
               pull_up_en[p]   <= 1'b0;
               pull_down_en[p] <= 1'b0;
            end else begin
               pull_up_en[p]   <= (psel == `WIM_PULL_UP) ||
                                  ((psel == `WIM_PULL_AUTO) && chan_lvl[p]);
               pull_down_en[p] <= (psel == `WIM_PULL_DOWN) ||
                                  ((psel == `WIM_PULL_AUTO) && !chan_lvl[p]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave. Address and data are taken in either order; one write at a time.

   reg        aw_held;
   reg        w_held;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire        wr_go   = aw_held && w_held && !s_axi_bvalid;
   wire [31:0] wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] wbits   = w_data & wmask;
   wire        wr_ctrl = wr_go && (aw_addr == `WIM_OFS_CTRL);
   wire        wr_en   = wr_go && (aw_addr == `WIM_OFS_WAKE_EN);
   wire        wr_pull = wr_go && (aw_addr == `WIM_OFS_PULL);
   wire        wr_filt = wr_go && (aw_addr == `WIM_OFS_FILT);
   wire        wr_t1   = wr_go && (aw_addr == `WIM_OFS_TMR1);
   wire        wr_t2   = wr_go && (aw_addr == `WIM_OFS_TMR2);
   wire        wr_wsrc = wr_go && (aw_addr == `WIM_OFS_WSRC);
   wire        wr_asrc = wr_go && (aw_addr == `WIM_OFS_ALT_WSRC);
   wire        wr_istat = wr_go && (aw_addr == `WIM_OFS_IRQ_STAT);
   wire        wr_imask = wr_go && (aw_addr == `WIM_OFS_IRQ_MASK);
   wire        wr_hit  = wr_ctrl || wr_en || wr_pull || wr_filt || wr_t1 || wr_t2 ||
                         wr_wsrc || wr_asrc || wr_istat || wr_imask ||
                         (aw_addr == `WIM_OFS_LEVEL);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WIM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `WIM_RESP_OKAY : `WIM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Plain read-write registers, merged per byte lane.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl                     <= 5'h00;
         wake_enable_control      <= 3'h0;
         pull_source_control      <= 6'h00;
         filter_mode_control      <= 6'h00;
         cyclic_timer_one_control <= 32'h00000000;
         cyclic_timer_two_control <= 32'h00000000;
         irq_mask                 <= 5'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl <= (ctrl & ~wmask[4:0]) | wbits[4:0];
         end
         if (wr_en) begin
            wake_enable_control <= (wake_enable_control & ~wmask[2:0]) | wbits[2:0];
         end
         if (wr_pull) begin
            pull_source_control <= (pull_source_control & ~wmask[5:0]) | wbits[5:0];
         end
         if (wr_filt) begin
            filter_mode_control <= (filter_mode_control & ~wmask[5:0]) | wbits[5:0];
         end
         if (wr_t1) begin
            cyclic_timer_one_control <= (cyclic_timer_one_control & ~wmask) | wbits;
         end
         if (wr_t2) begin
            cyclic_timer_two_control <= (cyclic_timer_two_control & ~wmask) | wbits;
         end
         if (wr_imask) begin
            irq_mask <= (irq_mask & ~wmask[4:0]) | wbits[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status, level and wake signalling. A new event wins over a clear in the same cycle.

   wire [4:0] evt_all = {alt_evt, wk_evt};
   wire [2:0] wsrc_clr = wr_wsrc ? wbits[2:0] : 3'h0;
   wire [1:0] asrc_clr = wr_asrc ? wbits[1:0] : 2'h0;
   wire [4:0] istat_clr = wr_istat ? wbits[4:0] : 5'h00;
   reg  [2:0] next_level;
   integer    k;

   always @* begin
      next_level = pin_level_status;
      for (k = 0; k < 3; k = k + 1) begin
         // Static sensing follows the pin; cyclic sensing keeps the last sampled level.
         if (!chan_gated[k] && (!chan_cyclic[k] || chan_lvl[k] != pin_level_status[k])) begin
            next_level[k] = chan_lvl[k];
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wake_source_status     <= 3'h0;
         alt_wake_source_status <= 2'h0;
         pin_level_status       <= 3'h0;
         irq_status             <= 5'h00;
         wake_request           <= 1'b0;
      end else begin
         wake_source_status     <= (wake_source_status & ~wsrc_clr) | wk_evt;
         alt_wake_source_status <= (alt_wake_source_status & ~asrc_clr) | alt_evt;
         pin_level_status       <= next_level;
         irq_status <= (irq_status & ~istat_clr) | (active_mode ? evt_all : 5'h00);
         wake_request <= !active_mode && (evt_all != 5'h00);
      end
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel.

   reg [31:0] rd_mux;
   reg        rd_hit;

   always @* begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         `WIM_OFS_CTRL:      rd_mux = {27'h0, ctrl};
         `WIM_OFS_WAKE_EN:   rd_mux = {29'h0, wake_enable_control};
         `WIM_OFS_PULL:      rd_mux = {26'h0, pull_source_control};
         `WIM_OFS_FILT:      rd_mux = {26'h0, filter_mode_control};
         `WIM_OFS_TMR1:      rd_mux = cyclic_timer_one_control;
         `WIM_OFS_TMR2:      rd_mux = cyclic_timer_two_control;
         `WIM_OFS_WSRC:      rd_mux = {29'h0, wake_source_status};
         `WIM_OFS_ALT_WSRC:  rd_mux = {30'h0, alt_wake_source_status};
         `WIM_OFS_LEVEL:     rd_mux = {29'h0, pin_level_status};
         `WIM_OFS_IRQ_STAT:  rd_mux = {27'h0, irq_status};
         `WIM_OFS_IRQ_MASK:  rd_mux = {27'h0, irq_mask};
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `WIM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? `WIM_RESP_OKAY : `WIM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // wim_top
`default_nettype wire
